// ---- shared/eal_pkg.sv ----
`default_nettype none

package eal_pkg;

  // Serial clock is the core clock divided by this figure
  localparam int EAL_SCK_DIV = 256;
  localparam int EAL_SCK_HALF = EAL_SCK_DIV / 2;
  localparam logic [6:0] EAL_HALF_LAST = 7'(EAL_SCK_HALF - 1);

  // Chip select sensing window before the first load
  localparam int EAL_CLK_PERIOD_NS = 50;
  localparam int EAL_SENSE_TIME_NS = 200;
  localparam int EAL_SENSE_CYC = (EAL_SENSE_TIME_NS + EAL_CLK_PERIOD_NS - 1) / EAL_CLK_PERIOD_NS;
  localparam logic [3:0] EAL_SENSE_LAST = 4'(EAL_SENSE_CYC - 1);

  // Word-organised read: start bit, two opcode bits, six address bits
  localparam logic [2:0] EAL_READ_OP = 3'h6;
  localparam logic [4:0] EAL_CMD_LAST = 5'h08;
  // Dummy zero plus sixteen data bits
  localparam logic [4:0] EAL_DATA_LAST = 5'h10;
  localparam int EAL_WORD_W = 16;
  localparam int EAL_NUM_WORDS = 4;
  localparam logic [1:0] EAL_LAST_WORD = 2'h3;

  // Word positions inside the EEPROM
  localparam int EAL_W_VENDOR = 0;
  localparam int EAL_W_DEVICE = 1;
  localparam int EAL_W_SUBVENDOR = 2;
  localparam int EAL_W_SUBSYS = 3;

  // Built-in identifier defaults; values are arbitrary
  localparam logic [15:0] EAL_DEF_VENDOR = 16'hA5C3;
  localparam logic [15:0] EAL_DEF_DEVICE = 16'h0F0F;
  localparam logic [15:0] EAL_DEF_SUBVENDOR = 16'hA5C3;
  localparam logic [15:0] EAL_DEF_SUBSYS = 16'h0001;

  localparam int EAL_NUM_UARTS = 4;
  localparam int EAL_MCR_IR_BIT = 6;

  typedef enum logic [2:0] {
    EAL_ST_SENSE,
    EAL_ST_GAP,
    EAL_ST_CMD,
    EAL_ST_DATA,
    EAL_ST_END,
    EAL_ST_DONE
  } eal_state_t;

  // Software hand control of the serial lines
  typedef struct packed {
    logic enable;
    logic sck;
    logic cs;
    logic wdata;
  } eal_manual_t;

endpackage

`default_nettype wire

// ---- src/eal_clk_div.sv ----
`timescale 1ns/1ps
`default_nettype none

module eal_clk_div
  import eal_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  // One-cycle pulse every half serial clock period
  output logic half_tick
);

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } eal_div_st_t;

  eal_div_st_t st_r;
  eal_div_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = 7'h00;
    end else if (st_r.cnt == EAL_HALF_LAST) begin
      st_nxt.cnt = 7'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign half_tick = st_r.tick;

endmodule // eal_clk_div

`default_nettype wire

// ---- src/eal_loader.sv ----
// How it works
// - During the reset-time load, serial clock is the core clock divided by 256.
// - Software may drive clock, select, write data and sample read data by hand.
// - Chip select level is sensed after reset to detect a fitted EEPROM.
// - Automatic load issues word-wide read commands and collects 16-bit words.
// - Without an EEPROM the load is skipped and built-in identifiers remain.
// - Software may store and read arbitrary EEPROM data through hand control.
// - Infrared strap is sampled after reset and after each soft reset.
// - Sampled strap is copied into bit 6 of every channel modem control.
// - Later software writes to that bit override the sampled strap.
// - First identifier word holds device id high, vendor id low.
// - Loaded identifiers are used only when an EEPROM is present.
`timescale 1ns/1ps
`default_nettype none

module eal_loader
  import eal_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Soft reset pulse from the device configuration registers
  input wire logic soft_reset,
  // EEPROM serial lines
  output logic eeprom_serial_clock,
  input wire logic eeprom_chip_select_in,
  output logic eeprom_chip_select_out,
  output logic eeprom_chip_select_oe,
  output logic eeprom_write_data,
  input wire logic eeprom_read_data,
  // Hand control register bits
  input wire eal_manual_t eeprom_manual_control_reg,
  output logic manual_read_data,
  // Infrared strap and modem control bit 6 per channel
  input wire logic infrared_enable_strap,
  input wire logic [EAL_NUM_UARTS-1:0] modem_control_wr,
  input wire logic [EAL_NUM_UARTS-1:0] modem_control_ir_wdata,
  output logic [EAL_NUM_UARTS-1:0] modem_control_ir,
  // Identifier words and load status
  output logic [31:0] id_word,
  output logic [31:0] subsys_word,
  output logic eeprom_present,
  output logic load_done
);

  typedef struct packed {
    eal_state_t fsm;
    logic [3:0] sense_cnt;
    logic [4:0] bit_cnt;
    logic [1:0] word_idx;
    logic [15:0] shreg;
    logic [EAL_NUM_WORDS-1:0][EAL_WORD_W-1:0] words;
    logic sck;
    logic cs;
    logic cs_oe;
    logic di;
    logic man_rd;
    logic present;
    logic done;
    logic strap_load;
    logic [EAL_NUM_UARTS-1:0] ir;
    logic [31:0] id;
    logic [31:0] sub;
  } eal_st_t;

  eal_st_t st_r;
  eal_st_t st_nxt;
  logic half_tick;
  logic div_run;
  logic [15:0] shifted;

  localparam eal_st_t EAL_RST = '{
    fsm: EAL_ST_SENSE,
    sense_cnt: 4'h0,
    bit_cnt: 5'h00,
    word_idx: 2'h0,
    shreg: 16'h0000,
    words: {EAL_DEF_SUBSYS, EAL_DEF_SUBVENDOR, EAL_DEF_DEVICE, EAL_DEF_VENDOR},
    sck: 1'b0,
    cs: 1'b0,
    cs_oe: 1'b0,
    di: 1'b0,
    man_rd: 1'b0,
    present: 1'b0,
    done: 1'b0,
    strap_load: 1'b1,
    ir: '0,
    id: {EAL_DEF_DEVICE, EAL_DEF_VENDOR},
    sub: {EAL_DEF_SUBSYS, EAL_DEF_SUBVENDOR}
  };

  assign div_run = (st_r.fsm != EAL_ST_SENSE) && (st_r.fsm != EAL_ST_DONE);
  assign shifted = {st_r.shreg[14:0], eeprom_read_data};

  eal_clk_div eal_clk_div_i (
    .clk(clk),
    .rst_b(rst_b),
    .run(div_run),
    .half_tick(half_tick)
  );

  always_comb begin
    st_nxt = st_r;

    // Strap capture first so that a same-cycle software write still wins
    if (st_r.strap_load) begin
      st_nxt.ir = {EAL_NUM_UARTS{infrared_enable_strap}};
      st_nxt.strap_load = 1'b0;
    end
    for (int i = 0; i < EAL_NUM_UARTS; i++) begin
      if (modem_control_wr[i]) begin
        st_nxt.ir[i] = modem_control_ir_wdata[i];
      end
    end
    if (soft_reset) begin
      st_nxt.strap_load = 1'b1;
    end

    unique case (st_r.fsm)
      EAL_ST_SENSE: begin
        // Select line released so the board pull-up can be seen
        st_nxt.cs_oe = 1'b0;
        st_nxt.sense_cnt = st_r.sense_cnt + 4'h1;
        if (st_r.sense_cnt == EAL_SENSE_LAST) begin
          st_nxt.present = eeprom_chip_select_in;
          st_nxt.cs_oe = 1'b1;
          st_nxt.cs = 1'b0;
          if (eeprom_chip_select_in) begin
            st_nxt.fsm = EAL_ST_GAP;
          end else begin
            st_nxt.fsm = EAL_ST_DONE;
            st_nxt.done = 1'b1;
          end
        end
      end
      EAL_ST_GAP: begin
        if (half_tick) begin
          st_nxt.cs = 1'b1;
          st_nxt.bit_cnt = 5'h00;
          st_nxt.shreg = {EAL_READ_OP, 4'h0, st_r.word_idx, 7'h00};
          st_nxt.di = EAL_READ_OP[2];
          st_nxt.fsm = EAL_ST_CMD;
        end
      end
      EAL_ST_CMD: begin
        if (half_tick) begin
          st_nxt.sck = ~st_r.sck;
          if (!st_r.sck) begin
            st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
            if (st_r.bit_cnt == EAL_CMD_LAST) begin
              st_nxt.bit_cnt = 5'h00;
              st_nxt.fsm = EAL_ST_DATA;
            end
          end else begin
            st_nxt.shreg = {st_r.shreg[14:0], 1'b0};
            st_nxt.di = st_r.shreg[14];
          end
        end
      end
      EAL_ST_DATA: begin
        if (half_tick) begin
          st_nxt.sck = ~st_r.sck;
          st_nxt.di = 1'b0;
          if (!st_r.sck) begin
            // Dummy zero falls off the top after sixteen more bits
            st_nxt.shreg = shifted;
            st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
            if (st_r.bit_cnt == EAL_DATA_LAST) begin
              st_nxt.words[st_r.word_idx] = shifted;
              st_nxt.fsm = EAL_ST_END;
            end
          end
        end
      end
      EAL_ST_END: begin
        if (half_tick) begin
          st_nxt.sck = 1'b0;
          st_nxt.cs = 1'b0;
          if (st_r.word_idx == EAL_LAST_WORD) begin
            st_nxt.fsm = EAL_ST_DONE;
            st_nxt.done = 1'b1;
            st_nxt.id = {st_r.words[EAL_W_DEVICE], st_r.words[EAL_W_VENDOR]};
            st_nxt.sub = {st_r.words[EAL_W_SUBSYS], st_r.words[EAL_W_SUBVENDOR]};
          end else begin
            st_nxt.word_idx = st_r.word_idx + 2'h1;
            st_nxt.fsm = EAL_ST_GAP;
          end
        end
      end
      EAL_ST_DONE: begin
        st_nxt.cs_oe = 1'b1;
        st_nxt.man_rd = eeprom_read_data;
        if (eeprom_manual_control_reg.enable) begin
          st_nxt.sck = eeprom_manual_control_reg.sck;
          st_nxt.cs = eeprom_manual_control_reg.cs;
          st_nxt.di = eeprom_manual_control_reg.wdata;
        end else begin
          st_nxt.sck = 1'b0;
          st_nxt.cs = 1'b0;
          st_nxt.di = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= EAL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign eeprom_serial_clock = st_r.sck;
  assign eeprom_chip_select_out = st_r.cs;
  assign eeprom_chip_select_oe = st_r.cs_oe;
  assign eeprom_write_data = st_r.di;
  assign manual_read_data = st_r.man_rd;
  assign modem_control_ir = st_r.ir;
  assign id_word = st_r.id;
  assign subsys_word = st_r.sub;
  assign eeprom_present = st_r.present;
  assign load_done = st_r.done;

endmodule // eal_loader

`default_nettype wire

// ---- test/eal_loader_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module eal_loader_chk
  import eal_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Inputs
  input wire logic soft_reset,
  input wire logic eeprom_chip_select_in,
  input wire eal_manual_t eeprom_manual_control_reg,
  input wire logic infrared_enable_strap,
  input wire logic [EAL_NUM_UARTS-1:0] modem_control_wr,
  input wire logic [EAL_NUM_UARTS-1:0] modem_control_ir_wdata,
  // Outputs
  input wire logic eeprom_serial_clock,
  input wire logic eeprom_chip_select_out,
  input wire logic eeprom_chip_select_oe,
  input wire logic [EAL_NUM_UARTS-1:0] modem_control_ir,
  input wire logic [31:0] id_word,
  input wire logic eeprom_present,
  input wire logic load_done
);
  logic [7:0] stay_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Cycles since the serial clock last moved
  always_ff @(posedge clk) begin
    if (!rst_b || $changed(eeprom_serial_clock)) begin
      stay_r <= 8'h00;
    end else begin
      stay_r <= stay_r + 8'h01;
    end
  end
  sequence s_sense;
    !eeprom_chip_select_oe [*4] ##1 eeprom_chip_select_oe;
  endsequence
  sequence s_quiet;
    !(|modem_control_wr) && $stable(infrared_enable_strap);
  endsequence
  property p_half;
    $fell(eeprom_serial_clock) && !load_done |-> stay_r == 8'h7F;
  endproperty
  property p_sense;
    $rose(rst_b) |-> s_sense;
  endproperty
  property p_skip;
    $rose(rst_b) ##3 !eeprom_chip_select_in |=> load_done && !eeprom_present
      && id_word == {EAL_DEF_DEVICE, EAL_DEF_VENDOR};
  endproperty
  property p_dflt;
    !load_done |-> id_word == {EAL_DEF_DEVICE, EAL_DEF_VENDOR};
  endproperty
  property p_strap;
    $rose(rst_b) && !(|modem_control_wr) |=>
      modem_control_ir == {EAL_NUM_UARTS{$past(infrared_enable_strap)}};
  endproperty
  property p_soft;
    soft_reset ##0 s_quiet [*4] |-> modem_control_ir == {EAL_NUM_UARTS{infrared_enable_strap}};
  endproperty
  property p_mcr;
    |modem_control_wr |=>
      ((modem_control_ir ^ $past(modem_control_ir_wdata)) & $past(modem_control_wr)) == 4'h0;
  endproperty
  property p_hand;
    load_done && eeprom_manual_control_reg.enable |=>
      eeprom_serial_clock == $past(eeprom_manual_control_reg.sck)
      && eeprom_chip_select_out == $past(eeprom_manual_control_reg.cs);
  endproperty
  a_half: assert property (p_half) else $error("half period");
  a_sense: assert property (p_sense) else $error("sense window");
  a_skip: assert property (p_skip) else $error("skip");
  a_dflt: assert property (p_dflt) else $error("early id");
  a_strap: assert property (p_strap) else $error("strap");
  a_soft: assert property (p_soft) else $error("soft strap");
  a_mcr: assert property (p_mcr) else $error("mcr write");
  a_hand: assert property (p_hand) else $error("hand control");
endmodule // eal_loader_chk
bind eal_loader eal_loader_chk eal_loader_chk_i (.clk, .rst_b, .soft_reset,
  .eeprom_chip_select_in, .eeprom_manual_control_reg, .infrared_enable_strap,
  .modem_control_wr, .modem_control_ir_wdata, .eeprom_serial_clock, .eeprom_chip_select_out,
  .eeprom_chip_select_oe, .modem_control_ir, .id_word, .eeprom_present, .load_done);
`default_nettype wire

// ---- test/eal_eeprom_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eal_eeprom_model
  import eal_pkg::*;
#(
  parameter logic [63:0] WORDS = 64'h0
)
(
  // Serial lines
  input wire logic sck,
  input wire logic cs,
  input wire logic di,
  output logic dout
);
  logic [8:0] cmd = 9'h000;
  int rises = 0;
  initial dout = 1'b1;
  always @(posedge cs) rises = 0;
  // Released output shows the inverse of its last bit
  always @(negedge cs) dout = ~dout;
  always @(posedge sck) begin
    if (cs && rises < 9) cmd = {cmd[7:0], di};
    if (cs) rises = rises + 1;
  end
  // Dummy zero, then D15..D0, each set up on the fall before its rise
  always @(negedge sck) begin
    if (cs && rises == 9) dout = 1'b0;
    else if (cs && rises > 9 && rises < 26)
      dout = (cmd[8:6] == EAL_READ_OP) ? WORDS[16 * int'(cmd[1:0]) + 25 - rises] : ~dout;
  end
endmodule // eal_eeprom_model
`default_nettype wire

// ---- test/eal_loader_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module eal_loader_test
  import eal_pkg::*;
;
  localparam logic [63:0] ROM = 64'hC001_5A5A_BEEF_1234;
  localparam logic [31:0] DEF_ID = {EAL_DEF_DEVICE, EAL_DEF_VENDOR};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic soft_reset = 1'b0;
  logic strap = 1'b1;
  logic fitted = 1'b1;
  logic [3:0] mwr = 4'h0;
  logic [3:0] mdat = 4'h0;
  eal_manual_t man = '0;
  logic sck, cs_out, cs_oe, cs_w, wdat, rd, mrd, present, done;
  logic [3:0] ir;
  logic [31:0] id, sub;
  logic [15:0] hw;
  int err_count = 0;
  int compares = 0;
  always #25 clk = ~clk;
  // Pull-up on the select pin only where an EEPROM is fitted
  assign cs_w = cs_oe ? cs_out : fitted;
  eal_loader eal_loader_i (.clk, .rst_b, .soft_reset, .eeprom_serial_clock(sck),
    .eeprom_chip_select_in(cs_w), .eeprom_chip_select_out(cs_out), .eeprom_chip_select_oe(cs_oe),
    .eeprom_write_data(wdat), .eeprom_read_data(rd), .eeprom_manual_control_reg(man),
    .manual_read_data(mrd), .infrared_enable_strap(strap), .modem_control_wr(mwr),
    .modem_control_ir_wdata(mdat), .modem_control_ir(ir), .id_word(id), .subsys_word(sub),
    .eeprom_present(present), .load_done(done));
  eal_eeprom_model #(.WORDS(ROM)) eal_eeprom_model_i (.sck, .cs(cs_w), .di(wdat), .dout(rd));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Word read by hand: select, nine command clocks, then dummy plus sixteen data bits
  task automatic hand_read(input logic [1:0] w, output logic [15:0] q);
    logic [8:0] c;
    c = {EAL_READ_OP, 4'h0, w};
    q = 16'h0000;
    man = 4'h8;
    step(2);
    man = 4'hA;
    step(2);
    for (int i = 8; i >= 0; i--) begin
      man = {3'h5, c[i]};
      step(2);
      man.sck = 1'b1;
      step(2);
    end
    for (int i = 0; i < 17; i++) begin
      man = 4'hA;
      step(2);
      q = {q[14:0], mrd};
      man.sck = 1'b1;
      step(2);
    end
    man = 4'h8;
    step(2);
  endtask
  task automatic restart;
    rst_b = 1'b0;
    step(16);
    rst_b = 1'b1;
    step(1);
  endtask
  initial begin
    restart;
    check(32'(ir), 32'hF);
    check(id, DEF_ID);
    for (int i = 0; i < 40000 && done !== 1'b1; i++) step(1);
    check(32'(done), 32'h1);
    if (done !== 1'b1) results;
    check(32'(present), 32'h1);
    check(id, ROM[31:0]);
    check(sub, ROM[63:32]);
    $display("test load finished");
    mwr = 4'h5;
    mdat = 4'h1;
    step(1);
    mwr = 4'h0;
    step(1);
    check(32'(ir), 32'hB);
    strap = 1'b0;
    step(1);
    soft_reset = 1'b1;
    step(1);
    soft_reset = 1'b0;
    step(4);
    check(32'(ir), 32'h0);
    $display("test modem control finished");
    man = 4'b1110;
    step(2);
    check(32'({sck, cs_out, wdat}), 32'h6);
    man = 4'b1011;
    step(2);
    check(32'({sck, cs_out, wdat}), 32'h3);
    check(32'(mrd), 32'(rd));
    hand_read(2'h2, hw);
    check(32'(hw), 32'(ROM[47:32]));
    $display("test hand control finished");
    fitted = 1'b0;
    restart;
    step(5);
    check(32'({present, done}), 32'h1);
    check(id, DEF_ID);
    $display("test skip finished");
    results;
  end
endmodule // eal_loader_test
`default_nettype wire
